/* File: logic/mab_bus_latch.sv */
// file: bus sequencer driving high address, muxed low address/data and the latch strobe
//
// Operation
// - high address byte; port address on I/O
// - float high address in hold, halt, reset
// - low address on shared bus in T1
// - after T1 shared bus carries data
// - latch strobe high in first clock state
// - latch strobe always driven, never floated
`timescale 1ns/1ns
`default_nettype none
module mab_bus_latch #(
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // core request stream
   input  wire logic                 reqValid,
   output logic                      reqReady,
   input  wire mab_pkg::mab_req_t    req,
   // core read answer
   output logic [7:0]                rdData,
   output logic                      rdValid,
   // bus mode inputs
   input  wire logic                 holdMode,
   input  wire logic                 haltMode,
   // external bus pins
   output mab_pkg::mab_pins_t        busPins,
   input  wire logic [7:0]           lowAddrDataIn
);
   import mab_pkg::*;

   mab_core_state_t st_reg;
   mab_core_state_t st_next;
   logic            qValid;
   logic            qReady;
   logic [MAB_REQ_W-1:0] qData;
   mab_req_t        qReq;
   logic            busFree;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   // an I/O access repeats its 8-bit port number on the high lines
   function automatic logic [7:0] highByte(input mab_req_t r);
      highByte = r.isIo ? r.addr[MAB_LOW_LSB +: 8] : r.addr[MAB_HIGH_LSB +: 8];
   endfunction : highByte

   function automatic logic [1:0] statusCode(input mab_req_t r);
      statusCode = r.isWrite ? MAB_ST_WRITE : MAB_ST_READ;
   endfunction : statusCode

   // ------------------------------------------------------------
   // request buffer: stalls the core only once all FIFO_DEPTH entries are full
   // ------------------------------------------------------------
   mab_fifo #(
      .WIDTH    (MAB_REQ_W),
      .DEPTH    (FIFO_DEPTH)
   ) u_fifo (
      .core_clk (core_clk),
      .rst      (rst),
      .inValid  (reqValid),
      .inReady  (reqReady),
      .inData   (req),
      .outValid (qValid),
      .outReady (qReady),
      .outData  (qData)
   );

   assign qReq    = mab_req_t'(qData);
   // a new cycle only starts with the bus released by hold and halt
   assign busFree = !holdMode && !haltMode;
   assign qReady  = (st_reg.phase == MAB_IDLE) && busFree;

   // ------------------------------------------------------------
   // sequencer: T1 split in two halves so the strobe can fall early
   // ------------------------------------------------------------
   always_comb
   begin
      st_next         = st_reg;
      st_next.rdValid = 1'b0;
      st_next.pins.ale = 1'b0;                                // strobe is low unless in T1A
      st_next.pins.highOe = busFree;                          // float in hold and halt
      case (st_reg.phase)
         MAB_IDLE:
         begin
            st_next.pins.lowOe = 1'b0;
            if (qValid && busFree)
            begin
               st_next.cur            = qReq;
               st_next.phase          = MAB_T1A;
               st_next.pins.ale       = 1'b1;
               st_next.pins.highAddr  = highByte(qReq);
               st_next.pins.lowOut    = qReq.addr[MAB_LOW_LSB +: 8];
               st_next.pins.lowOe     = 1'b1;
               st_next.pins.ioSel     = qReq.isIo;            // status stable around strobe fall
               st_next.pins.status    = statusCode(qReq);
            end
         end
         MAB_T1A:
         begin
            // strobe drops while the low address still sits on the bus
            st_next.phase = MAB_T1B;
         end
         MAB_T1B:
         begin
            // the bus turns to data only after a full cycle of strobe low
            st_next.phase      = MAB_T2;
            st_next.pins.lowOe = st_reg.cur.isWrite;
            if (st_reg.cur.isWrite)
               st_next.pins.lowOut = st_reg.cur.wdata;
         end
         MAB_T2:
         begin
            st_next.phase = MAB_T3;
         end
         MAB_T3:
         begin
            // read data is sampled at the last edge before the bus is released
            if (!st_reg.cur.isWrite)
            begin
               st_next.rdData  = lowAddrDataIn;
               st_next.rdValid = 1'b1;
            end
            st_next.pins.lowOe = 1'b0;
            st_next.phase      = MAB_IDLE;
         end
         default:
         begin
            st_next.phase      = MAB_IDLE;
            st_next.pins.lowOe = 1'b0;
         end
      endcase
   end

   // state register; reset releases the high and low address lines, strobe and status stay driven
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg             <= '0;                            // high lines float in reset
         st_reg.phase       <= MAB_IDLE;
         st_reg.pins.status <= MAB_ST_RESET;
         st_reg.pins.highAddr <= MAB_BYTE_RESET;
         st_reg.rdData      <= MAB_BYTE_RESET;
      end
      else
         st_reg <= st_next;
   end

   // ------------------------------------------------------------
   // outputs: strobe has no enable, it is always driven
   // ------------------------------------------------------------
   assign busPins = st_reg.pins;
   assign rdData  = st_reg.rdData;
   assign rdValid = st_reg.rdValid;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_high_addr_value: assert property ((st_reg.phase != MAB_IDLE) |->
      busPins.highAddr == highByte(st_reg.cur))
      else $error("high address byte does not match the cycle");

   a_high_addr_float: assert property ((holdMode || haltMode) |=> !busPins.highOe)
      else $error("high address driven during hold or halt");

   // depth 2 on the second state: by then the FIFO may already offer the next request
   a_low_addr_t1: assert property ((qValid && qReady) |=>
      (busPins.lowOe && busPins.lowOut == $past(qReq.addr[7:0])) ##1
      (busPins.lowOe && busPins.lowOut == $past(qReq.addr[7:0], 2)))
      else $error("low address not on the shared bus through T1");

   a_write_data_drive: assert property ((st_reg.phase == MAB_T1B && st_reg.cur.isWrite) |=>
      busPins.lowOe && busPins.lowOut == st_reg.cur.wdata ##1 busPins.lowOe ##1 !busPins.lowOe)
      else $error("write data not driven in T2 and T3");

   a_read_bus_free: assert property ((st_reg.phase inside {MAB_T2, MAB_T3}) &&
      !st_reg.cur.isWrite |-> !busPins.lowOe)
      else $error("device drives the shared bus on a read");

   a_read_capture: assert property ((st_reg.phase == MAB_T3 && !st_reg.cur.isWrite) |=>
      rdValid && rdData == $past(lowAddrDataIn))
      else $error("read data not returned");

   a_strobe_t1: assert property ((qValid && qReady) |=> busPins.ale ##1 !busPins.ale)
      else $error("strobe not a single pulse in the first state");

   a_strobe_only_t1: assert property (busPins.ale |-> st_reg.phase == MAB_T1A)
      else $error("strobe high outside the first state");

   a_strobe_fall_stable: assert property ($fell(busPins.ale) |->
      busPins.lowOe && $stable(busPins.lowOut) && $stable(busPins.status))
      else $error("shared bus changed before the strobe fell");

   // status must not move after the strobe, or a latch on its falling edge takes a mix
   a_status_steady: assert property ((st_reg.phase inside {MAB_T1B, MAB_T2, MAB_T3}) |->
      $stable(busPins.status) && $stable(busPins.ioSel))
      else $error("cycle status changed inside the machine cycle");

   // the reset check must run while reset is high, so it overrides the default disable
   // a floating strobe here would let peripherals latch garbage during reset
   a_pins_in_reset: assert property (disable iff (1'b0) rst |-> !busPins.highOe && !busPins.ale)
      else $error("high lines driven or strobe high during reset");

   // covers: one per main scenario, so a silent stimulus gap shows up as an unhit cover
   c_write_cycle: cover property (st_reg.phase == MAB_T3 && st_reg.cur.isWrite);
   c_read_cycle:  cover property (rdValid);
   c_io_cycle:    cover property (busPins.ale && busPins.ioSel);
   c_fifo_full:   cover property (reqValid && !reqReady);
   c_hold_stall:  cover property (holdMode && qValid);

endmodule : mab_bus_latch
`default_nettype wire

/* File: logic/mab_fifo.sv */
// file: request FIFO between the core and the bus sequencer
`timescale 1ns/1ns
`default_nettype none
module mab_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wrPtr;
      logic [PW-1:0]               rdPtr;
      logic [PW:0]                 count;
   } mab_fifo_state_t;

   mab_fifo_state_t st_reg;
   mab_fifo_state_t st_next;
   logic            doPush;
   logic            doPop;

   // ------------------------------------------------------------
   // handshakes: full and empty come straight from the count
   // ------------------------------------------------------------
   assign inReady  = (st_reg.count != (PW+1)'(DEPTH));
   assign outValid = (st_reg.count != '0);
   assign outData  = st_reg.mem[st_reg.rdPtr];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   // next state: pointers wrap at DEPTH so any depth works
   always_comb
   begin
      st_next = st_reg;
      if (doPush)
      begin
         st_next.mem[st_reg.wrPtr] = inData;
         st_next.wrPtr = (st_reg.wrPtr == PW'(DEPTH-1)) ? '0 : st_reg.wrPtr + PW'(1);
      end
      if (doPop)
         st_next.rdPtr = (st_reg.rdPtr == PW'(DEPTH-1)) ? '0 : st_reg.rdPtr + PW'(1);
      if (doPush && !doPop)
         st_next.count = st_reg.count + (PW+1)'(1);
      else if (doPop && !doPush)
         st_next.count = st_reg.count - (PW+1)'(1);
   end

   // state register
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

endmodule : mab_fifo
`default_nettype wire

/* File: logic/mab_pkg.sv */
// package: constants, carriers and state types of the muxed address/data bus front end
`default_nettype none
package mab_pkg;

   // ------------------------------------------------------------
   // widths, depths and reset values
   // ------------------------------------------------------------
   localparam int            MAB_ADDR_W     = 16;
   localparam int            MAB_DATA_W     = 8;
   localparam int            MAB_FIFO_DEPTH = 16;
   localparam int            MAB_LOW_LSB    = 0;     // low address byte position
   localparam int            MAB_HIGH_LSB   = 8;     // high address byte position
   localparam logic [1:0]    MAB_ST_RESET   = 2'h0;  // status code while no cycle has run
   localparam logic [1:0]    MAB_ST_WRITE   = 2'h1;  // status code of a write cycle
   localparam logic [1:0]    MAB_ST_READ    = 2'h2;  // status code of a read cycle
   localparam logic [7:0]    MAB_BYTE_RESET = 8'h00;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic                  isIo;
      logic                  isWrite;
      logic [15:0]           addr;
      logic [7:0]            wdata;
   } mab_req_t;

   localparam int            MAB_REQ_W = $bits(mab_req_t);

   typedef struct packed {
      logic [7:0]            highAddr;   // high address byte (port address on I/O)
      logic                  highOe;     // high address lines driven
      logic [7:0]            lowOut;     // shared low byte, address then data
      logic                  lowOe;      // shared low byte driven
      logic                  ale;        // address latch strobe, never floated
      logic                  ioSel;      // cycle status: I/O versus memory
      logic [1:0]            status;     // cycle status: {s1, s0}
   } mab_pins_t;

   typedef enum logic [2:0] {
      MAB_IDLE,
      MAB_T1A,
      MAB_T1B,
      MAB_T2,
      MAB_T3
   } mab_phase_t;

   typedef struct packed {
      mab_phase_t            phase;
      mab_req_t              cur;
      mab_pins_t             pins;
      logic [7:0]            rdData;
      logic                  rdValid;
   } mab_core_state_t;

endpackage : mab_pkg
`default_nettype wire

/* File: verif/mab_periph_model.sv */
// partner model: peripheral with its own address latch and read-back data
`timescale 1ns/1ns
`default_nettype none
module mab_periph_model
   import mab_pkg::*;
#(
   parameter logic [7:0] RD_KEY = 8'h5A
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // shared bus
   input  wire mab_pkg::mab_pins_t busPins,
   output logic [7:0]              lowAddrDataIn,
   // latched view
   output logic [7:0]              latAddr,
   output logic [2:0]              latStatus
);
   logic       aleDly;
   logic [1:0] driveCnt;
   logic [7:0] lastByte;
   // latch address and status at the clock edge after the strobe falls, then answer for three cycles
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         aleDly <= 1'b0;
         driveCnt <= 2'h0;
         latAddr <= 8'h00;
         latStatus <= 3'h0;
         lastByte <= 8'h00;
      end
      else
      begin
         aleDly <= busPins.ale;
         lastByte <= lowAddrDataIn;
         driveCnt <= (driveCnt != 2'h0) ? driveCnt - 2'h1 : 2'h0;
         if (aleDly && !busPins.ale)
         begin
            latAddr <= busPins.lowOut;
            latStatus <= {busPins.ioSel, busPins.status};
            driveCnt <= 2'h3;
         end
      end
   end
   // released lines do not keep the old byte: they toggle so a stale sample shows up
   assign lowAddrDataIn = busPins.lowOe ? busPins.lowOut : ((driveCnt != 2'h0) ? (latAddr ^ RD_KEY) : ~lastByte);
endmodule : mab_periph_model
`default_nettype wire

/* File: verif/testbench.sv */
// testbench: bus cycles, hold and halt, full request FIFO, reset
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mab_pkg::*;
   logic       core_clk, rst, reqValid, reqReady, rdValid, holdMode, haltMode;
   mab_req_t   req;
   mab_req_t   q [16];
   mab_pins_t  busPins;
   logic [7:0] rdData, lowAddrDataIn, latAddr;
   logic [2:0] latStatus;
   int         errorCnt = 0;
   int         checks = 0;

   mab_bus_latch #(.FIFO_DEPTH(16)) u_mab_bus_latch (.core_clk(core_clk), .rst(rst), .reqValid(reqValid),
      .reqReady(reqReady), .req(req), .rdData(rdData), .rdValid(rdValid), .holdMode(holdMode),
      .haltMode(haltMode), .busPins(busPins), .lowAddrDataIn(lowAddrDataIn));
   mab_periph_model u_mab_periph_model (.core_clk(core_clk), .rst(rst), .busPins(busPins),
      .lowAddrDataIn(lowAddrDataIn), .latAddr(latAddr), .latStatus(latStatus));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, errorCnt);
      if (errorCnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   // hold the request until an edge sees ready high
   task automatic push(input mab_req_t r);
      int n;
      n = 0;
      @(negedge core_clk);
      reqValid = 1'b1;
      req = r;
      while (reqReady !== 1'b1 && n < 50)
      begin
         @(negedge core_clk);
         n++;
      end
      check("taken", reqReady, 1'b1);
      @(negedge core_clk);
      reqValid = 1'b0;
   endtask : push

   // follow one machine cycle pin by pin; the wait is bounded since hold can stall it
   task automatic expect_cycle(input mab_req_t r);
      int n;
      n = 0;
      while (busPins.ale !== 1'b1 && n < 40)
      begin
         @(negedge core_clk);
         n++;
      end
      check("ale", busPins.ale, 1'b1);
      check("high", {busPins.highOe, busPins.highAddr}, {1'b1, r.isIo ? r.addr[7:0] : r.addr[15:8]});
      check("lowAddr", {busPins.lowOe, busPins.lowOut}, {1'b1, r.addr[7:0]});
      check("status", {busPins.ioSel, busPins.status}, {r.isIo, r.isWrite ? MAB_ST_WRITE : MAB_ST_READ});
      @(negedge core_clk);
      check("aleFall", {busPins.ale, busPins.lowOe, busPins.lowOut}, {2'b01, r.addr[7:0]});
      @(negedge core_clk);
      check("dataOe", busPins.lowOe, r.isWrite);
      if (r.isWrite)
         check("wdata", busPins.lowOut, r.wdata);
      check("latched", {latStatus, latAddr}, {r.isIo, r.isWrite ? MAB_ST_WRITE : MAB_ST_READ, r.addr[7:0]});
      if (!r.isWrite)
      begin
         n = 0;
         while (rdValid !== 1'b1 && n < 6)
         begin
            @(negedge core_clk);
            n++;
         end
         check("rdData", {rdValid, rdData}, {1'b1, r.addr[7:0] ^ 8'h5A});
      end
   endtask : expect_cycle

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_kinds();
      mab_req_t r;
      for (int k = 0; k < 4; k++)
      begin
         r = '{isIo: k[1], isWrite: k[0], addr: 16'hA5C3 + 16'(k) * 16'h1111, wdata: 8'h3C ^ 8'(k)};
         push(r);
         expect_cycle(r);
      end
   endtask : t_kinds

   // hold floats the high lines, keeps the strobe driven low and holds back the cycle
   task automatic t_hold();
      mab_req_t r;
      int       seen;
      r = '{isIo: 1'b0, isWrite: 1'b1, addr: 16'h7E81, wdata: 8'hC6};
      seen = 0;
      holdMode = 1'b1;
      repeat (2) @(negedge core_clk);
      check("holdFloat", {busPins.highOe, busPins.ale}, 2'b00);
      push(r);
      repeat (8)
      begin
         @(negedge core_clk);
         seen += int'(busPins.ale === 1'b1);
      end
      check("holdNoCycle", 16'(seen), 16'h0000);
      holdMode = 1'b0;
      expect_cycle(r);
   endtask : t_hold

   // halt lets the FIFO fill until it refuses, then the cycles drain with one idle clock between them
   task automatic t_fifo();
      haltMode = 1'b1;
      repeat (2) @(negedge core_clk);
      check("haltFloat", {busPins.highOe, busPins.ale}, 2'b00);
      for (int i = 0; i < 16; i++)
      begin
         q[i] = '{isIo: 1'b0, isWrite: i[0], addr: 16'(i) * 16'h1111, wdata: 8'(i)};
         push(q[i]);
      end
      check("full", reqReady, 1'b0);
      // a request offered while full must stay refused; it is withdrawn before halt ends
      reqValid = 1'b1;
      @(negedge core_clk);
      check("fullHeld", reqReady, 1'b0);
      reqValid = 1'b0;
      haltMode = 1'b0;
      for (int i = 0; i < 16; i++)
         expect_cycle(q[i]);
   endtask : t_fifo

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // watchdog well beyond the few hundred cycles the scenarios need
   initial
   begin
      #100000;
      errorCnt++;
      end_of_test();
   end

   initial
   begin
      rst = 1'b1;
      reqValid = 1'b0;
      req = '0;
      holdMode = 1'b0;
      haltMode = 1'b0;
      repeat (2) @(negedge core_clk);
      check("reset", {busPins.highOe, busPins.lowOe, busPins.ale, reqReady}, 4'h1);
      rst = 1'b0;
      t_kinds();
      t_hold();
      t_fifo();
      rst = 1'b1;
      @(negedge core_clk);
      check("midReset", {busPins.highOe, busPins.lowOe, busPins.ale, rdValid, reqReady}, 5'h01);
      rst = 1'b0;
      // one read after the second release: the sequencer must restart from idle
      push(q[2]);
      expect_cycle(q[2]);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
